// >>> common/tsc_pkg.sv
package tsc_pkg;
  // message type select on the queue write port
  localparam logic [2:0] MSG_NONE = 3'h0;
  localparam logic [2:0] MSG_ERROR = 3'h1;
  localparam logic [2:0] MSG_WATCH = 3'h2;
  localparam logic [2:0] MSG_OWNER = 3'h3;
  localparam logic [2:0] MSG_DSTAT = 3'h4;
  localparam logic [2:0] MSG_BRANCH = 3'h5;
  // overrun error encodings
  localparam logic [4:0] ERR_PT_ONLY = 5'h01;
  localparam logic [4:0] ERR_OT_PT = 5'h07;
  localparam logic [4:0] ERR_WP_ONLY = 5'h06;
  localparam logic [4:0] ERR_WP_MIX = 5'h08;
  // collision loss encoding, same class as program trace loss
  localparam logic [4:0] ERR_COLLIDE = 5'h01;
  // transfer codes
  localparam logic [5:0] TC_IND_HIST = 6'h1c;
  localparam logic [5:0] TC_IND_HIST_SYNC = 6'h1d;
  localparam logic [5:0] TC_DIR = 6'h03;
  localparam logic [5:0] TC_IND = 6'h04;
  localparam logic [5:0] TC_DIR_SYNC = 6'h0b;
  localparam logic [5:0] TC_IND_SYNC = 6'h0c;
  // counter limits, history reset value and queue size
  localparam logic [7:0] PERIODIC_MAX = 8'hff;
  localparam logic [7:0] ICNT_MAX = 8'hff;
  localparam logic [31:0] HIST_RESET = 32'h00000001;
  localparam int QUEUE_DEPTH = 32;
  localparam int QPTR_W = 5;
endpackage

// >>> hdl/tsc_sat_counter.sv
`timescale 1ns/1ps
module tsc_sat_counter
  import tsc_pkg::*;
#(
  parameter logic [7:0] MAX = 8'hff
) (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic inc_in,
  output logic [7:0] count_out,
  output logic hit_out
);
  // hit is raised in the cycle whose increment takes the count to its limit, one cycle before count_out shows it; clr wins
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      count_out <= 8'h00;
    end else if (inc_in && count_out != MAX) begin
      count_out <= count_out + 8'h01;
    end
  end
  assign hit_out = inc_in && !clr_in && (count_out == MAX - 8'h01);
endmodule

// >>> hdl/tsc_trace_sync.sv
`timescale 1ns/1ps
// Overview of operation
// R1: test-logic-reset clears queue pointers, counters, state and registers.
// R2: first branch after system reset gives a sync branch message.
// R3: enabling program trace makes the next trace message a sync one.
// R4: leaving low power or debug makes the next branch message sync.
// R5: on overrun, discard every incoming message until queue empties.
// R6: after draining, queue one error recording discarded message types.
// R7: after overrun the next branch message queued is sync form.
// R8: after 255 queued trace messages force sync and reset the counter.
// R9: event-in pin, when enabled, makes next branch sync.
// R10: instruction count reaching 255 forces sync and resets the counter.
// R11: branch to secure memory is dropped; next branch is sync.
// R12: instruction count after secure suppression may be inaccurate.
// R13: queue admission priority: error, watchpoint, ownership, status, branch.
// R14: colliding branch dropped, error sent, next branch sync; no error is sent when branch_secure_in is set.
// R15: dropped branch keeps instruction count unless it shifts a history bit; it accumulates onward.
// R16: history buffer kept when branch lost to collision.
// R17: in full 32-bit mode a preempted branch still shifts a history bit.
// R18: overrun codes 00001 trace, 00111 ownership+trace, 01000 with watchpoint.
// R19: overrun code 00110 when only watchpoints were discarded.
// R20: sync history message uses transfer code 011101 and full address.
// R21: each sync trigger sets a pending flag cleared by a sync branch.
module tsc_trace_sync
  import tsc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic tlr_in,
  // control
  input wire logic module_en_in,
  input wire logic trace_en_in,
  input wire logic event_in_ctrl_in,
  input wire logic event_in_pin_n_in,
  input wire logic secure_part_in,
  input wire logic history_mode_in,
  // core events
  input wire logic lowpwr_dbg_in,
  input wire logic seq_instr_in,
  input wire logic pred_in,
  input wire logic pred_taken_in,
  input wire logic branch_in,
  input wire logic branch_ind_in,
  input wire logic branch_taken_in,
  input wire logic branch_secure_in,
  input wire logic [31:0] branch_addr_in,
  // other message sources
  input wire logic watch_req_in,
  input wire logic owner_req_in,
  input wire logic dstat_req_in,
  // queue drain side
  input wire logic q_pop_in,
  // queue write port
  output logic q_push_out,
  output logic [2:0] q_type_out,
  output logic [5:0] q_tcode_out,
  output logic [4:0] q_err_out,
  output logic [7:0] q_icnt_out,
  output logic [31:0] q_hist_out,
  output logic [31:0] q_addr_out,
  output logic q_full_addr_out,
  // status
  output logic sync_pend_out,
  output logic overrun_out,
  output logic [QPTR_W:0] q_level_out
);
  typedef enum logic [1:0] {TSC_RUN, TSC_DRAIN, TSC_ERR} tsc_state_t;
  tsc_state_t state_r;
  logic clr;
  logic trace_en_d_r, lowpwr_d_r, evt_d_r, rst_seen_r;
  logic sync_pend_r, drop_wp_r, drop_ot_r, drop_pt_r, coll_err_r;
  logic [QPTR_W:0] level_r;
  logic [7:0] icnt_r, per_cnt;
  logic [31:0] hist_r;
  logic [4:0] err_code;
  logic tracing, br_msg, hi_req, q_full, push, push_br, per_hit, icnt_hit;
  logic icnt_inc, evt_edge, trig, hist_shift, icnt_hit_r;
  logic [7:0] icnt_unused;

  assign clr = rst_in || tlr_in; // [R1]
  assign tracing = module_en_in && trace_en_in;
  // a message only carries a branch when the flow really changed
  assign br_msg = tracing && branch_in && branch_taken_in &&
                  (branch_ind_in || !history_mode_in);
  assign hi_req = watch_req_in || owner_req_in || dstat_req_in;
  assign q_full = (level_r == (QPTR_W+1)'(QUEUE_DEPTH)) && !q_pop_in;
  assign evt_edge = evt_d_r && !event_in_pin_n_in;

  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      trace_en_d_r <= 1'b0;
      lowpwr_d_r <= 1'b0;
      evt_d_r <= 1'b1;
    end else begin
      trace_en_d_r <= tracing;
      lowpwr_d_r <= lowpwr_dbg_in;
      evt_d_r <= event_in_pin_n_in;
    end
  end

  // overrun state: drain fully, then one error message
  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      state_r <= TSC_RUN;
    end else begin
      unique case (state_r)
        TSC_RUN: if ((br_msg || hi_req) && q_full) state_r <= TSC_DRAIN; // [R5]
        TSC_DRAIN: if (level_r == '0) state_r <= TSC_ERR; // [R5]
        TSC_ERR: state_r <= TSC_RUN; // [R6]
        default: state_r <= TSC_RUN;
      endcase
    end
  end

  // record message classes discarded while draining
  always_ff @(posedge sys_clk_in) begin
    if (clr || state_r == TSC_ERR) begin
      drop_wp_r <= 1'b0;
      drop_ot_r <= 1'b0;
      drop_pt_r <= 1'b0;
    end else if (state_r != TSC_RUN || q_full) begin
      drop_wp_r <= drop_wp_r || watch_req_in;
      drop_ot_r <= drop_ot_r || owner_req_in || dstat_req_in;
      drop_pt_r <= drop_pt_r || br_msg;
    end
  end

  always_comb begin
    if (drop_wp_r && (drop_ot_r || drop_pt_r)) begin
      err_code = ERR_WP_MIX; // [R18]
    end else if (drop_wp_r) begin
      err_code = ERR_WP_ONLY; // [R19]
    end else if (drop_ot_r) begin
      err_code = ERR_OT_PT; // [R18]
    end else begin
      err_code = ERR_PT_ONLY; // [R18]
    end
  end

  // collision loss error goes out the cycle after the loss of a branch without branch_secure_in
  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      coll_err_r <= 1'b0;
    end else if (state_r == TSC_RUN && !q_full) begin
      coll_err_r <= br_msg && hi_req && !branch_secure_in; // [R14]
    end
  end

  // arbitration: error wins, then watchpoint, ownership, status, branch
  logic [2:0] sel;
  always_comb begin
    sel = MSG_NONE;
    if (state_r == TSC_ERR || (state_r == TSC_RUN && coll_err_r)) begin
      sel = MSG_ERROR; // [R13]
    end else if (state_r != TSC_RUN || q_full) begin
      sel = MSG_NONE; // [R5]
    end else if (watch_req_in) begin
      sel = MSG_WATCH; // [R13]
    end else if (owner_req_in) begin
      sel = MSG_OWNER; // [R13]
    end else if (dstat_req_in) begin
      sel = MSG_DSTAT; // [R13]
    end else if (br_msg && !(secure_part_in && branch_secure_in)) begin
      sel = MSG_BRANCH; // [R11]
    end
  end
  assign push = sel != MSG_NONE;
  assign push_br = sel == MSG_BRANCH;

  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      level_r <= '0;
    end else if (push && !q_pop_in) begin
      level_r <= level_r + 1'b1;
    end else if (!push && q_pop_in && level_r != '0) begin
      level_r <= level_r - 1'b1;
    end
  end

  // sync triggers
  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
    end
  end
  assign trig = !rst_seen_r // [R2]
    || (tracing && !trace_en_d_r) // [R3]
    || (lowpwr_d_r && !lowpwr_dbg_in) // [R4]
    || (state_r == TSC_ERR) // [R7]
    || per_hit // [R8]
    || (tracing && event_in_ctrl_in && evt_edge) // [R9]
    || icnt_hit // [R10]
    || (br_msg && secure_part_in && branch_secure_in) // [R11]
    || (br_msg && hi_req && state_r == TSC_RUN); // [R14]

  // set wins over the clear from a sync message
  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      sync_pend_r <= 1'b1; // [R2]
    end else if (trig) begin
      sync_pend_r <= 1'b1; // [R21]
    end else if (push_br) begin
      sync_pend_r <= 1'b0; // [R21]
    end
  end

  tsc_sat_counter #(.MAX(PERIODIC_MAX)) u_periodic (
    .clk_in(sys_clk_in),
    .clr_in(clr || (push_br && sync_pend_r)),
    .inc_in(push_br && !sync_pend_r),
    .count_out(per_cnt),
    .hit_out(per_hit)
  ); // [R8]

  // instruction count kept across dropped branches; it is cleared only
  // by a queued branch, a history bit or the overflow restart. after secure suppression the
  // count is not aligned to an instruction boundary
  assign hist_shift = tracing && history_mode_in &&
    (pred_in || (branch_in && !branch_ind_in) ||
     (branch_in && branch_ind_in && !branch_taken_in) || // [R17]
     (br_msg && hi_req)); // [R17]
  assign icnt_inc = tracing && seq_instr_in;
  // overflow restarts the count one cycle after the limit; a direct
  // feedback of the hit would loop through the counter's clear
  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      icnt_hit_r <= 1'b0;
    end else begin
      icnt_hit_r <= icnt_hit; // [R10]
    end
  end
  tsc_sat_counter #(.MAX(ICNT_MAX)) u_icnt (
    .clk_in(sys_clk_in),
    .clr_in(clr || push_br || hist_shift || icnt_hit_r), // [R15] [R12]
    .inc_in(icnt_inc),
    .count_out(icnt_r),
    .hit_out(icnt_hit)
  ); // [R10]
  assign icnt_unused = per_cnt;

  // history held on collision loss, restarted only when a message carries it
  always_ff @(posedge sys_clk_in) begin
    if (clr || push_br) begin
      hist_r <= HIST_RESET;
    end else if (hist_shift) begin
      hist_r <= {hist_r[30:0], pred_in ? pred_taken_in : branch_taken_in}; // [R16]
    end
  end

  logic [5:0] tcode;
  always_comb begin
    if (history_mode_in) begin
      tcode = sync_pend_r ? TC_IND_HIST_SYNC : TC_IND_HIST; // [R20]
    end else if (branch_ind_in) begin
      tcode = sync_pend_r ? TC_IND_SYNC : TC_IND;
    end else begin
      tcode = sync_pend_r ? TC_DIR_SYNC : TC_DIR;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (clr) begin
      q_push_out <= 1'b0;
      q_type_out <= MSG_NONE;
      q_tcode_out <= 6'h00;
      q_err_out <= 5'h00;
      q_icnt_out <= 8'h00;
      q_hist_out <= 32'h00000000;
      q_addr_out <= 32'h00000000;
      q_full_addr_out <= 1'b0;
    end else begin
      q_push_out <= push;
      q_type_out <= sel;
      q_tcode_out <= push_br ? tcode : 6'h00;
      q_err_out <= (state_r == TSC_ERR) ? err_code : // [R6]
                   (sel == MSG_ERROR ? ERR_COLLIDE : 5'h00); // [R14]
      q_icnt_out <= push_br ? icnt_r : 8'h00;
      q_hist_out <= push_br ? hist_r : 32'h00000000;
      q_addr_out <= push_br ? branch_addr_in : 32'h00000000;
      q_full_addr_out <= push_br && sync_pend_r; // [R20]
    end
  end

  assign sync_pend_out = sync_pend_r;
  assign overrun_out = state_r != TSC_RUN;
  assign q_level_out = level_r;

  a_sync_clear: assert property (@(posedge sys_clk_in) disable iff (clr)
    push_br && sync_pend_r && !trig |=> !sync_pend_r) // [R21]
    else $error("pending sync not cleared");
  a_sync_tcode: assert property (@(posedge sys_clk_in) disable iff (clr)
    push_br && sync_pend_r && history_mode_in |=>
    q_tcode_out == TC_IND_HIST_SYNC && q_full_addr_out) // [R20]
    else $error("sync history tcode wrong");
  a_drain_drop: assert property (@(posedge sys_clk_in) disable iff (clr)
    state_r == TSC_DRAIN |=> !q_push_out) // [R5]
    else $error("push during drain");
  a_err_after: assert property (@(posedge sys_clk_in) disable iff (clr)
    state_r == TSC_DRAIN && level_r == '0 |=> ##1
    q_push_out && q_type_out == MSG_ERROR) // [R6]
    else $error("no error after drain");
  a_ovr_sync: assert property (@(posedge sys_clk_in) disable iff (clr)
    state_r == TSC_ERR |=> sync_pend_r) // [R7]
    else $error("overrun did not arm sync");
  a_coll_drop: assert property (@(posedge sys_clk_in) disable iff (clr)
    br_msg && hi_req |-> !push_br) // [R14]
    else $error("branch admitted on collision");
  a_watch_prio: assert property (@(posedge sys_clk_in) disable iff (clr)
    watch_req_in && push && !coll_err_r && state_r == TSC_RUN |->
    sel == MSG_WATCH) // [R13]
    else $error("watchpoint lost priority");
  a_secure_drop: assert property (@(posedge sys_clk_in) disable iff (clr)
    br_msg && secure_part_in && branch_secure_in |=> sync_pend_r) // [R11]
    else $error("secure branch did not arm sync");
  a_icnt_keep: assert property (@(posedge sys_clk_in) disable iff (clr)
    br_msg && hi_req && !hist_shift && !icnt_inc && !icnt_hit_r |=>
    icnt_r == $past(icnt_r)) // [R15]
    else $error("count lost on drop");
endmodule

// >>> sim/tsc_drain_model.sv
`timescale 1ns/1ps
module tsc_drain_model
  import tsc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // control and queue state
  input wire logic stall_in,
  input wire logic [QPTR_W:0] q_level_in,
  // drain strobe
  output logic q_pop_out
);
  // pops every other cycle at most, so a level that lags a pop by one
  // cycle can never make the tool drain an entry that is not there
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q_pop_out <= 1'b0;
    end else begin
      q_pop_out <= !stall_in && (q_level_in != '0) && !q_pop_out;
    end
  end
endmodule

// >>> sim/tsc_trace_sync_tb_top.sv
`timescale 1ns/1ps
module tsc_trace_sync_tb_top
  import tsc_pkg::*;
;
  logic sys_clk_in, rst_in, tlr_in, module_en_in, trace_en_in, stall;
  logic event_in_ctrl_in, event_in_pin_n_in, secure_part_in, history_mode_in;
  logic lowpwr_dbg_in, seq_instr_in, pred_in, pred_taken_in, branch_in;
  logic branch_ind_in, branch_taken_in, branch_secure_in, q_pop_in;
  logic watch_req_in, owner_req_in, dstat_req_in, q_push_out;
  logic q_full_addr_out, sync_pend_out, overrun_out;
  logic [2:0] q_type_out;
  logic [5:0] q_tcode_out;
  logic [4:0] q_err_out;
  logic [7:0] q_icnt_out;
  logic [31:0] branch_addr_in, q_hist_out, q_addr_out, seed;
  logic [QPTR_W:0] q_level_out;
  logic [2:0] tbl [4] = '{3'b001, 3'b011, 3'b100, 3'b101};
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  tsc_trace_sync i_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .tlr_in(tlr_in),
    .module_en_in(module_en_in), .trace_en_in(trace_en_in),
    .event_in_ctrl_in(event_in_ctrl_in),
    .event_in_pin_n_in(event_in_pin_n_in),
    .secure_part_in(secure_part_in), .history_mode_in(history_mode_in),
    .lowpwr_dbg_in(lowpwr_dbg_in), .seq_instr_in(seq_instr_in),
    .pred_in(pred_in), .pred_taken_in(pred_taken_in),
    .branch_in(branch_in), .branch_ind_in(branch_ind_in),
    .branch_taken_in(branch_taken_in), .branch_secure_in(branch_secure_in),
    .branch_addr_in(branch_addr_in), .watch_req_in(watch_req_in),
    .owner_req_in(owner_req_in), .dstat_req_in(dstat_req_in),
    .q_pop_in(q_pop_in), .q_push_out(q_push_out), .q_type_out(q_type_out),
    .q_tcode_out(q_tcode_out), .q_err_out(q_err_out),
    .q_icnt_out(q_icnt_out), .q_hist_out(q_hist_out),
    .q_addr_out(q_addr_out), .q_full_addr_out(q_full_addr_out),
    .sync_pend_out(sync_pend_out), .overrun_out(overrun_out),
    .q_level_out(q_level_out)
  );

  tsc_drain_model i_tool (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .stall_in(stall),
    .q_level_in(q_level_out), .q_pop_out(q_pop_in)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // generous ceiling: the whole sequence needs under two thousand cycles
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [5:0] exp_tc(input logic hist, input logic sync);
    if (hist) begin
      return sync ? TC_IND_HIST_SYNC : TC_IND_HIST;
    end
    return sync ? TC_IND_SYNC : TC_IND;
  endfunction

  // seen holds {watchpoint, ownership, branch} attempts while draining
  function automatic logic [4:0] exp_err(input logic [2:0] seen);
    if (seen[2]) begin
      return (seen[1:0] != 2'b00) ? ERR_WP_MIX : ERR_WP_ONLY;
    end
    return seen[1] ? ERR_OT_PT : ERR_PT_ONLY;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks = checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  // r is {branch, watch, owner, status, secure}; returns where the
  // registered answer to the request can be sampled
  task automatic req(input logic [4:0] r);
    @(posedge sys_clk_in);
    {branch_in, watch_req_in, owner_req_in, dstat_req_in,
     branch_secure_in} <= r;
    seed = xs(seed);
    branch_addr_in <= {seed[31:1], 1'b0};
    @(posedge sys_clk_in);
    {branch_in, watch_req_in, owner_req_in, dstat_req_in,
     branch_secure_in} <= '0;
    #1;
  endtask

  task automatic branch_chk(input logic sync, input string what);
    req(5'b10000);
    cmp(q_push_out, 1'b1, what);
    cmp(q_type_out, MSG_BRANCH, what);
    cmp(q_tcode_out, exp_tc(history_mode_in, sync), what);
    cmp(q_full_addr_out, sync, what);
    if (sync) begin
      cmp(q_addr_out, branch_addr_in, what);
    end
    cmp(sync_pend_out, 1'b0, what);
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {tlr_in, branch_in, watch_req_in, owner_req_in, dstat_req_in} = '0;
    {branch_secure_in, secure_part_in, lowpwr_dbg_in, seq_instr_in} = '0;
    {pred_in, pred_taken_in, event_in_ctrl_in, stall} = '0;
    {rst_in, module_en_in, trace_en_in, history_mode_in} = '1;
    {event_in_pin_n_in, branch_ind_in, branch_taken_in} = '1;
    branch_addr_in = '0;
    seed = 32'h00000030;
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    cmp(sync_pend_out, 1'b1, "pending after reset");
    cmp(q_level_out, 0, "level after reset");
    branch_chk(1'b1, "first branch");
    branch_chk(1'b0, "plain branch");
    @(posedge sys_clk_in);
    trace_en_in <= 1'b0;
    @(posedge sys_clk_in);
    trace_en_in <= 1'b1;
    branch_chk(1'b1, "trace enabled");
    @(posedge sys_clk_in);
    lowpwr_dbg_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    lowpwr_dbg_in <= 1'b0;
    branch_chk(1'b1, "low power exit");
    for (int c = 0; c < 2; c++) begin
      @(posedge sys_clk_in);
      {event_in_ctrl_in, history_mode_in} <= {c[0], c[0]};
      event_in_pin_n_in <= 1'b0;
      @(posedge sys_clk_in);
      event_in_pin_n_in <= 1'b1;
      branch_chk(c[0], "event in");
    end
    @(posedge sys_clk_in);
    secure_part_in <= 1'b1;
    req(5'b10001);
    cmp(q_push_out, 1'b0, "secure branch dropped");
    branch_chk(1'b1, "after secure");
    for (int s = 0; s < 3; s++) begin
      req(5'b10000 | (5'b01000 >> s));
      cmp(q_type_out, MSG_WATCH + s, "collision winner");
      @(posedge sys_clk_in);
      #1;
      cmp({q_push_out, q_type_out, q_err_out},
          {1'b1, MSG_ERROR, ERR_COLLIDE}, "collision error");
      branch_chk(1'b1, "after collision");
      cmp(q_hist_out, 32'h00000003, "history kept");
    end
    @(posedge sys_clk_in);
    {history_mode_in, seq_instr_in} <= 2'b01;
    repeat (3) @(posedge sys_clk_in);
    seq_instr_in <= 1'b0;
    req(5'b11000);
    @(posedge sys_clk_in);
    seq_instr_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    seq_instr_in <= 1'b0;
    branch_chk(1'b1, "count after loss");
    cmp(q_icnt_out, 8'h05, "count after loss");
    @(posedge sys_clk_in);
    seq_instr_in <= 1'b1;
    repeat (255) @(posedge sys_clk_in);
    seq_instr_in <= 1'b0;
    branch_chk(1'b1, "count overflow");
    cmp(q_icnt_out, 8'h00, "count restart");
    repeat (254) branch_chk(1'b0, "periodic run");
    req(5'b10000);
    cmp({q_push_out, q_tcode_out}, {1'b1, exp_tc(history_mode_in, 1'b0)},
        "periodic limit");
    cmp(sync_pend_out, 1'b1, "periodic limit");
    branch_chk(1'b1, "periodic sync");
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_in);
      stall <= 1'b1;
      for (int n = 0; n < 40 && q_level_out != QUEUE_DEPTH; n++) req(5'b00100);
      cmp(q_level_out, QUEUE_DEPTH, "queue full");
      if (tbl[k][0]) req(5'b10000);
      if (tbl[k][1]) req(5'b00100);
      if (tbl[k][2]) req(5'b01000);
      cmp(overrun_out, 1'b1, "overrun");
      @(posedge sys_clk_in);
      stall <= 1'b0;
      for (int n = 0; n < 200 && q_push_out !== 1'b1; n++) begin
        @(posedge sys_clk_in);
        #1;
      end
      cmp({q_push_out, q_type_out, q_err_out},
          {1'b1, MSG_ERROR, exp_err(tbl[k])}, "overrun error");
      branch_chk(1'b1, "after overrun");
    end
    @(posedge sys_clk_in);
    stall <= 1'b1;
    repeat (3) req(5'b00100);
    @(posedge sys_clk_in);
    tlr_in <= 1'b1;
    @(posedge sys_clk_in);
    tlr_in <= 1'b0;
    #1;
    cmp({q_level_out, sync_pend_out, overrun_out}, {6'h00, 1'b1, 1'b0},
        "test logic reset");
    give_verdict();
  end
endmodule
